//--- hw/uwd_window.sv
// How it works
// (R1) All registers share an 8-byte window; mapping follows line and additional control.
// (R2) Divisor access bit set makes offsets 0 and 1 reach the divisor bytes.
// (R3) With divisor access, offset 0 reads and writes divisor bits 7..0.
// (R4) With divisor access, offset 1 reads and writes divisor bits 15..8.
// (R5) One line control format drives both transmitter and receiver.
// (R6) Writing 0xBF to line control opens the enhanced register set.
// (R7) Writing 0xBF sets only bit 7; bits 6..0 keep their values.
// (R8) Software leaves enhanced mapping by writing an ordinary line control value.
// (R9) Additional control bit 7 maps the extended status registers into the window.
// (R10) Additional control bit 6 enables reads of the indexed set window.
// (R11) Normal write to offset 0 loads the transmit holding byte.
// (R12) Offset 7 is scratch storage and the index for the indexed set.
// (R13) Normal read of offset 0 returns the oldest received character.
// (R14) Offset 2 writes fifo control and reads interrupt status.
// (R15) Holding and interrupt enable registers answer only with divisor access clear.
// (R16) Standard registers other than line control and the divisor answer only when last line control write was not 0xBF.
// (R17) Enhanced and flow character registers answer only after a 0xBF write.
`timescale 1ns/1ps
module uwd_window
   import uwd_pkg::*;
#(
   parameter int DATA_W = 8
)
(
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   input  wire logic [2:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   output logic             reg_rvalid,
   input  wire logic [7:0]  rx_data,
   input  wire logic [7:0]  isr_in,
   input  wire logic [7:0]  lsr_in,
   input  wire logic [7:0]  msr_in,
   input  wire logic [7:0]  asr_in,
   input  wire logic [7:0]  rx_level,
   input  wire logic [7:0]  tx_level,
   output logic      [7:0]  tx_data,
   output logic             tx_load,
   output logic             rx_pop,
   output logic      [7:0]  fifo_ctrl,
   output logic             fifo_ctrl_load,
   output logic      [15:0] divisor,
   output logic      [7:0]  line_control,
   output logic             enhanced_map,
   output logic      [7:0]  interrupt_enable,
   output logic      [7:0]  modem_control,
   output logic      [7:0]  scratch_index,
   output logic      [7:0]  enhanced_features,
   output logic      [7:0]  xon1,
   output logic      [7:0]  xon2,
   output logic      [7:0]  xoff1,
   output logic      [7:0]  xoff2,
   output logic      [7:0]  additional_control
);
   if (DATA_W != 8)
   begin : g_check
      $error("uwd_window serves byte-wide data only");
   end

   logic       dlab;
   logic       map950;
   logic       icr_rd;
   logic       ld_dll;
   logic       ld_dlm;
   logic       ld_ier;
   logic       ld_mcr;
   logic       ld_spr;
   logic       ld_efr;
   logic       ld_xon1;
   logic       ld_xon2;
   logic       ld_xoff1;
   logic       ld_xoff2;
   logic       ld_acr;
   logic [7:0] next_rdata;

   assign dlab   = line_control[LCR_DLAB_BIT];
   assign map950 = additional_control[ACR_MAP_BIT];
   assign icr_rd = additional_control[ACR_ICR_BIT];

   // Write decode of the shared window
   always_comb
   begin
      ld_dll   = 1'b0;
      ld_dlm   = 1'b0;
      ld_ier   = 1'b0;
      ld_mcr   = 1'b0;
      ld_spr   = 1'b0;
      ld_efr   = 1'b0;
      ld_xon1  = 1'b0;
      ld_xon2  = 1'b0;
      ld_xoff1 = 1'b0;
      ld_xoff2 = 1'b0;
      ld_acr   = 1'b0;
      if (reg_wr)
      begin
         case (reg_addr)                                      // [R1]
            OFS_DATA:     ld_dll = dlab;                        // [R2] [R3]
            OFS_IER_DLM:
            begin
               ld_dlm = dlab;                                   // [R4]
               ld_ier = !dlab;                                  // [R15]
            end
            OFS_FIFO_ISR: ld_efr = enhanced_map;                // [R17]
            OFS_MCR:
            begin
               ld_xon1 = enhanced_map;                          // [R17]
               ld_mcr  = !enhanced_map;                         // [R16]
            end
            OFS_LSR:
            begin
               ld_xon2 = enhanced_map;                          // [R17]
               ld_acr  = !enhanced_map && (scratch_index == IDX_ACR); // [R12]
            end
            OFS_MSR:      ld_xoff1 = enhanced_map;              // [R17]
            OFS_SCRATCH:
            begin
               ld_xoff2 = enhanced_map;                         // [R17]
               ld_spr   = !enhanced_map;                        // [R12] [R16]
            end
            default:
            begin
               ld_dll = 1'b0;
            end
         endcase
      end
   end

   // Byte registers of the window
   uwd_byte_reg #(.WIDTH(8), .RESET(RST_BYTE)) u_dll
      (.clk_sys(clk_sys), .arst_n(arst_n), .load(ld_dll), .din(reg_wdata), .q(divisor[7:0]));
   uwd_byte_reg #(.WIDTH(8), .RESET(RST_BYTE)) u_dlm
      (.clk_sys(clk_sys), .arst_n(arst_n), .load(ld_dlm), .din(reg_wdata), .q(divisor[15:8]));
   uwd_byte_reg #(.WIDTH(8), .RESET(RST_BYTE)) u_ier
      (.clk_sys(clk_sys), .arst_n(arst_n), .load(ld_ier), .din(reg_wdata),
       .q(interrupt_enable));
   uwd_byte_reg #(.WIDTH(8), .RESET(RST_BYTE)) u_mcr
      (.clk_sys(clk_sys), .arst_n(arst_n), .load(ld_mcr), .din(reg_wdata), .q(modem_control));
   uwd_byte_reg #(.WIDTH(8), .RESET(RST_BYTE)) u_spr
      (.clk_sys(clk_sys), .arst_n(arst_n), .load(ld_spr), .din(reg_wdata), .q(scratch_index));
   uwd_byte_reg #(.WIDTH(8), .RESET(RST_BYTE)) u_efr
      (.clk_sys(clk_sys), .arst_n(arst_n), .load(ld_efr), .din(reg_wdata),
       .q(enhanced_features));
   uwd_byte_reg #(.WIDTH(8), .RESET(RST_BYTE)) u_xon1
      (.clk_sys(clk_sys), .arst_n(arst_n), .load(ld_xon1), .din(reg_wdata), .q(xon1));
   uwd_byte_reg #(.WIDTH(8), .RESET(RST_BYTE)) u_xon2
      (.clk_sys(clk_sys), .arst_n(arst_n), .load(ld_xon2), .din(reg_wdata), .q(xon2));
   uwd_byte_reg #(.WIDTH(8), .RESET(RST_BYTE)) u_xoff1
      (.clk_sys(clk_sys), .arst_n(arst_n), .load(ld_xoff1), .din(reg_wdata), .q(xoff1));
   uwd_byte_reg #(.WIDTH(8), .RESET(RST_BYTE)) u_xoff2
      (.clk_sys(clk_sys), .arst_n(arst_n), .load(ld_xoff2), .din(reg_wdata), .q(xoff2));
   uwd_byte_reg #(.WIDTH(8), .RESET(RST_ACR)) u_acr
      (.clk_sys(clk_sys), .arst_n(arst_n), .load(ld_acr), .din(reg_wdata),
       .q(additional_control));

   // Line control and enhanced unlock; one format serves both directions
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         line_control <= RST_LCR;
         enhanced_map <= 1'b0;
      end
      else if (reg_wr && reg_addr == OFS_LCR)
      begin
         if (reg_wdata == LCR_UNLOCK)
         begin
            line_control[LCR_DLAB_BIT] <= 1'b1;                  // [R7] [R5]
            enhanced_map               <= 1'b1;                  // [R6]
         end
         else
         begin
            line_control <= reg_wdata;                           // [R5]
            enhanced_map <= 1'b0;                                // [R8]
         end
      end
   end

   // Strobes to the serial engine and fifo control
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tx_data        <= 8'h00;
         tx_load        <= 1'b0;
         fifo_ctrl      <= 8'h00;
         fifo_ctrl_load <= 1'b0;
         rx_pop         <= 1'b0;
      end
      else
      begin
         tx_load        <= reg_wr && reg_addr == OFS_DATA && !dlab;        // [R11] [R15]
         fifo_ctrl_load <= reg_wr && reg_addr == OFS_FIFO_ISR && !enhanced_map; // [R14]
         rx_pop         <= reg_rd && reg_addr == OFS_DATA && !dlab;        // [R13]
         if (reg_wr && reg_addr == OFS_DATA && !dlab)
         begin
            tx_data <= reg_wdata;                                          // [R11]
         end
         if (reg_wr && reg_addr == OFS_FIFO_ISR && !enhanced_map)
         begin
            fifo_ctrl <= reg_wdata;                                        // [R14] [R16]
         end
      end
   end

   // Read multiplexer of the shared window
   always_comb
   begin
      next_rdata = 8'h00;
      case (reg_addr)                                                      // [R1]
         OFS_DATA:     next_rdata = dlab ? divisor[7:0] : rx_data;         // [R3] [R13]
         OFS_IER_DLM:
         begin
            if (dlab)
               next_rdata = divisor[15:8];                                 // [R4]
            else if (map950)
               next_rdata = asr_in;                                        // [R9]
            else
               next_rdata = interrupt_enable;                              // [R15]
         end
         OFS_FIFO_ISR: next_rdata = enhanced_map ? enhanced_features : isr_in; // [R14] [R17]
         OFS_LCR:      next_rdata = (map950 && !enhanced_map) ? rx_level : line_control; // [R9]
         OFS_MCR:
         begin
            if (enhanced_map)
               next_rdata = xon1;                                          // [R17]
            else if (map950)
               next_rdata = tx_level;                                      // [R9]
            else
               next_rdata = modem_control;                                 // [R16]
         end
         OFS_LSR:
         begin
            if (enhanced_map)
               next_rdata = xon2;                                          // [R17]
            else if (icr_rd)
               next_rdata = (scratch_index == IDX_ACR) ? additional_control : 8'h00; // [R10]
            else
               next_rdata = lsr_in;                                        // [R16]
         end
         OFS_MSR:      next_rdata = enhanced_map ? xoff1 : msr_in;         // [R16] [R17]
         OFS_SCRATCH:  next_rdata = enhanced_map ? xoff2 : scratch_index;  // [R12]
         default:      next_rdata = 8'h00;
      endcase
   end

   // Registered read answer, one cycle after the strobe
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_rd;
         if (reg_rd)
         begin
            reg_rdata <= next_rdata;
         end
      end
   end
endmodule

//--- hw/uwd_pkg.sv
package uwd_pkg;
   // Window offsets
   localparam logic [2:0] OFS_DATA     = 3'h0;
   localparam logic [2:0] OFS_IER_DLM  = 3'h1;
   localparam logic [2:0] OFS_FIFO_ISR = 3'h2;
   localparam logic [2:0] OFS_LCR      = 3'h3;
   localparam logic [2:0] OFS_MCR      = 3'h4;
   localparam logic [2:0] OFS_LSR      = 3'h5;
   localparam logic [2:0] OFS_MSR      = 3'h6;
   localparam logic [2:0] OFS_SCRATCH  = 3'h7;
   // Line control unlock value and bit positions in line and additional control
   localparam logic [7:0] LCR_UNLOCK   = 8'hbf;
   localparam int         LCR_DLAB_BIT = 7;
   localparam int         ACR_MAP_BIT  = 7;
   localparam int         ACR_ICR_BIT  = 6;
   // Index of the additional control register within the indexed set
   localparam logic [7:0] IDX_ACR      = 8'h00;
   // Values after reset
   localparam logic [7:0] RST_LCR      = 8'h00;
   localparam logic [7:0] RST_BYTE     = 8'h00;
   localparam logic [7:0] RST_ACR      = 8'h00;
endpackage

//--- hw/uwd_byte_reg.sv
`timescale 1ns/1ps
module uwd_byte_reg
#(
   parameter int               WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET = '0
)
(
   input  wire logic             clk_sys,
   input  wire logic             arst_n,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] q
);
   // Host writable storage byte
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         q <= RESET;
      end
      else if (load)
      begin
         q <= din;
      end
   end
endmodule

//--- verification/uwd_window_monitor.sv
`timescale 1ns/1ps
module uwd_window_monitor
   import uwd_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        arst_n,
   input wire logic [2:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata,
   input wire logic        reg_rvalid,
   input wire logic [7:0]  rx_data,
   input wire logic [7:0]  tx_data,
   input wire logic        tx_load,
   input wire logic        rx_pop,
   input wire logic [7:0]  fifo_ctrl,
   input wire logic        fifo_ctrl_load,
   input wire logic [15:0] divisor,
   input wire logic [7:0]  line_control,
   input wire logic        enhanced_map,
   input wire logic [7:0]  scratch_index,
   input wire logic [7:0]  enhanced_features
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // Write strobes for offsets 0 to 3
   wire w0 = reg_wr && reg_addr == OFS_DATA;
   wire w1 = reg_wr && reg_addr == OFS_IER_DLM;
   wire w2 = reg_wr && reg_addr == OFS_FIFO_ISR;
   wire w3 = reg_wr && reg_addr == OFS_LCR;
   // Receive read answer and its one-cycle pulse
   sequence rx_answer;
      reg_rvalid && rx_pop && reg_rdata == $past(rx_data) ##1 (!rx_pop || $past(reg_rd));
   endsequence
   rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("no read answer");
   rx_read_a: assert property (reg_rd && reg_addr == OFS_DATA && !line_control[7] |=> rx_answer)
      else $error("rx read wrong");
   tx_write_a: assert property (w0 && !line_control[7] |=> tx_load && tx_data == $past(reg_wdata))
      else $error("tx load wrong");
   div_low_a: assert property (w0 && line_control[7]
      |=> !tx_load && divisor[7:0] == $past(reg_wdata))
      else $error("divisor low wrong");
   div_high_a: assert property (w1 && line_control[7] |=> divisor[15:8] == $past(reg_wdata))
      else $error("divisor high wrong");
   unlock_keep_a: assert property (w3 && reg_wdata == LCR_UNLOCK |=> enhanced_map
      && line_control == {1'b1, $past(line_control[6:0])}) else $error("unlock wrong");
   lcr_load_a: assert property (w3 && reg_wdata != LCR_UNLOCK |=> !enhanced_map
      && line_control == $past(reg_wdata)) else $error("line control load wrong");
   scratch_a: assert property (reg_wr && reg_addr == OFS_SCRATCH && !enhanced_map
      |=> scratch_index == $past(reg_wdata)) else $error("scratch wrong");
   fifo_ctrl_a: assert property (w2 && !enhanced_map |=> fifo_ctrl_load
      && fifo_ctrl == $past(reg_wdata)) else $error("fifo control wrong");
   efr_write_a: assert property (w2 && enhanced_map |=> !fifo_ctrl_load
      && enhanced_features == $past(reg_wdata)) else $error("features wrong");
endmodule
bind uwd_window uwd_window_monitor u_uwd_window_monitor (.clk_sys, .arst_n, .reg_addr, .reg_wr,
   .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .rx_data, .tx_data, .tx_load, .rx_pop,
   .fifo_ctrl, .fifo_ctrl_load, .divisor, .line_control, .enhanced_map, .scratch_index,
   .enhanced_features);

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   import uwd_pkg::*;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata, tx_data, interrupt_status, line_status, modem_status, asr, rxl, txl, rxd, d, sv, fctl;
   // Offsets that reach the enhanced set after the unlock write
   logic [2:0] enh_ofs [5] = '{OFS_FIFO_ISR, OFS_MCR, OFS_LSR, OFS_MSR, OFS_SCRATCH};
   logic reg_rvalid;
   logic [31:0] seed = 32'h9;
   logic [7:0] expq[$];
   int fails = 0;
   int comparisons = 0;
   always #10 clk_sys = ~clk_sys;
   uwd_window u_uwd_window (.clk_sys, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata, .reg_rvalid, .rx_data(rxd), .isr_in(interrupt_status), .lsr_in(line_status), .msr_in(modem_status),
      .asr_in(asr), .rx_level(rxl), .tx_level(txl), .tx_data, .tx_load(), .rx_pop(),
      .fifo_ctrl(fctl), .fifo_ctrl_load(), .divisor(), .line_control(), .enhanced_map(),
      .interrupt_enable(), .modem_control(), .scratch_index(), .enhanced_features(),
      .xon1(), .xon2(), .xoff1(), .xoff2(), .additional_control());
   // Xorshift source
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One-cycle write strobe
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask
   // One-cycle read strobe, expectation queued
   task automatic rd(input logic [2:0] a, input logic [7:0] v);
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      expq.push_back(v);
      @(negedge clk_sys);
      reg_rd = 1'b0;
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Read answers compared against the oldest note
   always @(posedge clk_sys)
   begin
      if (reg_rvalid === 1'b1)
      begin
         if (expq.size() == 0)
            check("unexpected answer", 8'h00, 8'hff);
         else
            check("read data", reg_rdata, expq.pop_front());
      end
   end
   initial
   begin
      {interrupt_status, line_status, modem_status, asr, rxl, txl, rxd} = '0;
      repeat (20) @(negedge clk_sys);
      arst_n = 1'b1;
      {interrupt_status, line_status, modem_status, asr, rxl, txl, rxd} = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
      rd(OFS_LCR, RST_LCR);
      sv = rnd();
      wr(OFS_SCRATCH, sv);
      rd(OFS_SCRATCH, sv);
      $display("done: reset and scratch");
      wr(OFS_LCR, 8'h83);
      d = rnd();
      wr(OFS_DATA, d);
      rd(OFS_DATA, d);
      wr(OFS_IER_DLM, ~d);
      rd(OFS_IER_DLM, ~d);
      $display("done: divisor");
      wr(OFS_LCR, LCR_UNLOCK);
      rd(OFS_LCR, 8'h83);
      foreach (enh_ofs[i])
      begin
         d = rnd();
         wr(enh_ofs[i], d);
         rd(enh_ofs[i], d);
      end
      $display("done: enhanced set");
      wr(OFS_LCR, 8'h03);
      rd(OFS_LCR, 8'h03);
      rd(OFS_SCRATCH, sv);
      rd(OFS_FIFO_ISR, interrupt_status);
      rd(OFS_LSR, line_status);
      wr(OFS_MSR, ~modem_status);
      rd(OFS_MSR, modem_status);
      d = rnd();
      wr(OFS_IER_DLM, d);
      rd(OFS_IER_DLM, d);
      wr(OFS_MCR, ~d);
      rd(OFS_MCR, ~d);
      wr(OFS_FIFO_ISR, d);
      check("fifo control", fctl, d);
      rd(OFS_FIFO_ISR, interrupt_status);
      wr(OFS_DATA, ~d);
      check("tx data", tx_data, ~d);
      rd(OFS_DATA, rxd);
      $display("done: normal map");
      wr(OFS_SCRATCH, IDX_ACR);
      wr(OFS_LSR, 8'hc0);
      rd(OFS_LSR, 8'hc0);
      wr(OFS_SCRATCH, 8'h01);
      rd(OFS_LSR, 8'h00);
      rd(OFS_IER_DLM, asr);
      rd(OFS_LCR, rxl);
      rd(OFS_MCR, txl);
      $display("done: extended map");
      for (int i = 0; i < 20 && expq.size() != 0; i++)
         @(posedge clk_sys);
      check("pending answers", 8'(expq.size()), 8'h00);
      report_and_stop();
   end
endmodule
